// ===== rtl/isf_map.svh
// Purpose: constants of the serial target front end (field positions, reset values, counts)
// Assumes: included by bare name from the package and the design modules
// Notes: definitions only
`ifndef ISF_MAP_SVH
`define ISF_MAP_SVH

// ----------------------------------------------------------------------------
// target address
// ----------------------------------------------------------------------------
`define ISF_ADDR_FIXED 3'h4
`define ISF_ADDR_W 7
`define ISF_ADDR_RST 7'h00

// ----------------------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------------------
`define ISF_BYTE_W 8
`define ISF_LAST_BIT 4'h7
`define ISF_ACK_LOW 4'h8
`define ISF_ACK_HIGH 4'h9
`define ISF_CNT_RST 4'h0
`define ISF_BYTE_RST 8'h00

// ----------------------------------------------------------------------------
// reset and strap capture
// ----------------------------------------------------------------------------
`define ISF_STRAP_WAIT 2'h3
`define ISF_STRAP_TAKE 2'h1
`define ISF_PIN_RST 8'hC0

// ----------------------------------------------------------------------------
// receive buffer
// ----------------------------------------------------------------------------
`define ISF_BUF_W 9
`define ISF_BUF_DEPTH 2

`endif

// ===== rtl/isf_pkg.sv
// Purpose: types and shared decoding of the serial target front end
// Assumes: isf_map.svh holds the numeric constants
// Notes: no timing in here
`include "isf_map.svh"

package isf_pkg;

  // ----------------------------------------------------------------------------
  // framing states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_ACK   = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_RACK  = 3'h5,
    ST_WAIT  = 3'h6
  } isf_state_e;

  // pad comparator report of one four-state strap pin
  typedef enum logic [1:0] {
    PAD_GROUND   = 2'h0,
    PAD_RESISTOR = 2'h1,
    PAD_FLOATING = 2'h2,
    PAD_HIGH     = 2'h3
  } isf_pad_e;

  // strap state to two address bits
  function automatic logic [1:0] isf_strap_bits(input logic [1:0] pad);
    logic [1:0] bits;
    case (isf_pad_e'(pad))
      PAD_GROUND: bits = 2'h0;
      PAD_RESISTOR: bits = 2'h1;
      PAD_FLOATING: bits = 2'h2;
      PAD_HIGH: bits = 2'h3;
      default: bits = 2'h0;
    endcase
    return bits;
  endfunction : isf_strap_bits

endpackage : isf_pkg

// ===== rtl/isf_buf2.sv
// Purpose: small valid/ready buffer holding received bytes for the user side
// Assumes: one clock; DEPTH a power of two
// Notes: in_ready_out is honest, the framer refuses a byte when it is low
`timescale 1ns/1ps
`default_nettype none
`include "isf_map.svh"

module isf_buf2 import isf_pkg::*; #(
  parameter int WIDTH = `ISF_BUF_W,
  parameter int DEPTH = `ISF_BUF_DEPTH
) (
  input wire logic clock_in,              // system clock
  input wire logic reset_in,              // synchronous reset, high
  input wire logic in_valid_in,           // word offered
  input wire logic [WIDTH-1:0] in_data_in, // word
  output logic in_ready_out,              // room for a word
  output logic out_valid_out,             // word available
  output logic [WIDTH-1:0] out_data_out,  // oldest word
  input wire logic out_ready_in           // drain side takes word
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // ----------------------------------------------------------------------------
  // handshakes and next state
  // ----------------------------------------------------------------------------
  assign in_ready_out = (cnt_q != CW'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // pointers wrap naturally since depth is a power of two
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_in;
      wr_d = wr_q + PW'(1);
    end
    if (pop) begin
      rd_d = rd_q + PW'(1);
    end
    case ({push, pop})
      2'b10: cnt_d = cnt_q + CW'(1);
      2'b01: cnt_d = cnt_q - CW'(1);
      default: cnt_d = cnt_q;
    endcase
  end

  // registers only
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

endmodule : isf_buf2

`default_nettype wire

// ===== rtl/isf_target.sv
// Purpose: serial bus target front end: address decode, start/stop, byte framing, acknowledge
// Assumes: scl_in is the master's clock and may stand still between frames
// Notes: open-drain data pin; the pad always drives low when enabled
`timescale 1ns/1ps
`default_nettype none
`include "isf_map.svh"

module isf_target import isf_pkg::*; (
  input wire logic clock_in,                 // system clock, 200 MHz
  input wire logic reset_in,                 // reset, high; synchronous except on the two serial clock flops, cleared asynchronously
  input wire logic scl_in,                   // serial clock from master
  input wire logic sda_in,                   // serial data level at the pin
  output logic sda_out,                      // data drive value, always low
  output logic sda_oe_out,                   // high while pulling data low
  input wire logic [1:0] addr_strap_high_in, // pad state of upper strap
  input wire logic [1:0] addr_strap_low_in,  // pad state of lower strap
  output logic [6:0] own_addr_out,           // address taken from straps
  output logic start_out,                    // pulse per start seen
  output logic stop_out,                     // pulse per stop seen
  output logic selected_out,                 // level, addressed in this frame until a no-acknowledge
  output logic read_mode_out,                // level, direction of frame
  output logic rx_valid_out,                 // received byte waiting
  output logic [7:0] rx_data_out,            // received byte
  output logic rx_cmd_out,                   // byte is the command byte
  input wire logic rx_ready_in,              // user takes received byte
  input wire logic [7:0] tx_data_in,         // byte to send in a read
  output logic tx_load_out                   // pulse when tx_data_in taken
);

  // ----------------------------------------------------------------------------
  // link clock domain: one sample per rising serial clock
  // ----------------------------------------------------------------------------
  logic bit_val_q, bit_val_d, bit_tgl_q, bit_tgl_d;

  // data is stable while clock is high, so the rising edge sees a settled bit
  always_comb begin
    bit_val_d = sda_in;
    bit_tgl_d = ~bit_tgl_q;
  end

  // the clock may not run at reset, hence the asynchronous clear to constants
  always_ff @(posedge scl_in or posedge reset_in) begin
    if (reset_in) begin
      bit_val_q <= 1'b0;
      bit_tgl_q <= 1'b0;
    end else begin
      bit_val_q <= bit_val_d;
      bit_tgl_q <= bit_tgl_d;
    end
  end

  // ----------------------------------------------------------------------------
  // synchronisers into the system domain
  // ----------------------------------------------------------------------------
  // bit order: 7 scl, 6 sda, 5 toggle, 4 sampled bit, 3:2 high strap, 1:0 low
  logic [7:0] pin_s1_q, pin_s2_q, pin_s1_d, pin_s2_d;
  logic [2:0] pin_s3_q, pin_s3_d;
  logic bit_evt_q, bit_evt_d;
  logic scl_s, sda_s, bit_s;
  logic start_w, stop_w, fall_w;

  always_comb begin
    pin_s1_d = {scl_in, sda_in, bit_tgl_q, bit_val_q, addr_strap_high_in, addr_strap_low_in};
    pin_s2_d = pin_s1_q;
    pin_s3_d = pin_s2_q[7:5];
    bit_evt_d = pin_s2_q[5] ^ pin_s3_q[0];
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pin_s1_q <= `ISF_PIN_RST;
      pin_s2_q <= `ISF_PIN_RST;
      pin_s3_q <= 3'h6;
      bit_evt_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      pin_s3_q <= pin_s3_d;
      bit_evt_q <= bit_evt_d;
    end
  end

  // the bit is read one cycle after its toggle, so it has surely settled
  assign scl_s = pin_s2_q[7];
  assign sda_s = pin_s2_q[6];
  assign bit_s = pin_s2_q[4];
  assign start_w = scl_s & pin_s3_q[2] & pin_s3_q[1] & ~sda_s;
  assign stop_w = scl_s & pin_s3_q[2] & ~pin_s3_q[1] & sda_s;
  assign fall_w = pin_s3_q[2] & ~scl_s;

  // ----------------------------------------------------------------------------
  // own address from the straps
  // ----------------------------------------------------------------------------
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic [6:0] addr_q, addr_d;
  logic addr_ok_q, addr_ok_d;

  // straps are taken once the synchroniser holds real pin levels
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    addr_d = addr_q;
    addr_ok_d = addr_ok_q;
    if (strap_cnt_q != 2'h0) begin
      strap_cnt_d = strap_cnt_q - 2'h1;
    end
    if (strap_cnt_q == `ISF_STRAP_TAKE) begin
      addr_d = {`ISF_ADDR_FIXED, isf_strap_bits(pin_s2_q[3:2]),
                isf_strap_bits(pin_s2_q[1:0])};
      addr_ok_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      strap_cnt_q <= `ISF_STRAP_WAIT;
      addr_q <= `ISF_ADDR_RST;
      addr_ok_q <= 1'b0;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      addr_q <= addr_d;
      addr_ok_q <= addr_ok_d;
    end
  end

  // ----------------------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------------------
  logic push_w, buf_ready_w;
  logic [8:0] push_data_w;
  logic [8:0] buf_out_w;

  isf_buf2 #(
    .WIDTH(`ISF_BUF_W),
    .DEPTH(`ISF_BUF_DEPTH)
  ) u_rx_buf (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .in_valid_in(push_w),
    .in_data_in(push_data_w),
    .in_ready_out(buf_ready_w),
    .out_valid_out(rx_valid_out),
    .out_data_out(buf_out_w),
    .out_ready_in(rx_ready_in)
  );

  // buffer words are flops, so the data output is registered
  assign rx_cmd_out = buf_out_w[8];
  assign rx_data_out = buf_out_w[7:0];

  // ----------------------------------------------------------------------------
  // byte framer
  // ----------------------------------------------------------------------------
  isf_state_e state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] cnt_q, cnt_d;
  logic oe_q, oe_d, rd_q, rd_d, ack_q, ack_d, first_q, first_d;
  logic start_q, stop_q, load_q, load_d;
  logic [7:0] byte_w;

  assign byte_w = {shift_q[6:0], bit_s};

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    rd_d = rd_q;
    ack_d = ack_q;
    first_d = first_q;
    load_d = 1'b0;
    push_w = 1'b0;
    push_data_w = {first_q, byte_w};
    if (start_w) begin
      state_d = ST_ADDR;
      cnt_d = `ISF_CNT_RST;
      oe_d = 1'b0;
    end else if (stop_w) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (bit_evt_q) begin
            shift_d = byte_w;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `ISF_LAST_BIT) begin
              rd_d = bit_s;
              ack_d = 1'b1;
              first_d = 1'b1;
              // mismatch leaves the pin released until a new start
              state_d = (addr_ok_q && shift_q[6:0] == addr_q) ? ST_ACK : ST_WAIT;
            end
          end
        end
        ST_ACK: begin
          if (bit_evt_q) begin
            cnt_d = cnt_q + 4'h1;
          end else if (fall_w && cnt_q == `ISF_ACK_LOW) begin
            oe_d = ack_q;
          end else if (fall_w && cnt_q == `ISF_ACK_HIGH) begin
            oe_d = 1'b0;
            cnt_d = `ISF_CNT_RST;
            if (!ack_q) begin
              state_d = ST_WAIT;
            end else if (rd_q) begin
              shift_d = tx_data_in;
              oe_d = ~tx_data_in[7];
              load_d = 1'b1;
              state_d = ST_RDATA;
            end else begin
              state_d = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (bit_evt_q) begin
            shift_d = byte_w;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `ISF_LAST_BIT) begin
              // a full buffer refuses the byte with a no-acknowledge
              push_w = buf_ready_w;
              ack_d = buf_ready_w;
              first_d = 1'b0;
              state_d = ST_ACK;
            end
          end
        end
        ST_RDATA: begin
          if (bit_evt_q) begin
            cnt_d = cnt_q + 4'h1;
          end else if (fall_w && cnt_q == `ISF_ACK_LOW) begin
            oe_d = 1'b0;
            state_d = ST_RACK;
          end else if (fall_w) begin
            shift_d = {shift_q[6:0], 1'b0};
            oe_d = ~shift_q[6];
          end
        end
        ST_RACK: begin
          if (bit_evt_q) begin
            cnt_d = cnt_q + 4'h1;
            // master no-acknowledge ends the read; wait for its stop
            if (bit_s) begin
              state_d = ST_WAIT;
            end
          end else if (fall_w && cnt_q == `ISF_ACK_HIGH) begin
            shift_d = tx_data_in;
            oe_d = ~tx_data_in[7];
            load_d = 1'b1;
            cnt_d = `ISF_CNT_RST;
            state_d = ST_RDATA;
          end
        end
        ST_IDLE, ST_WAIT: begin
          oe_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // framer registers; start, stop and load events are registered so those outputs are flops
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      shift_q <= `ISF_BYTE_RST;
      cnt_q <= `ISF_CNT_RST;
      oe_q <= 1'b0;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      first_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      first_q <= first_d;
      start_q <= start_w;
      stop_q <= stop_w;
      load_q <= load_d;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_q;
  assign own_addr_out = addr_q;
  assign start_out = start_q;
  assign stop_out = stop_q;
  assign tx_load_out = load_q;
  assign selected_out = (state_q == ST_ACK) || (state_q == ST_WDATA) ||
                        (state_q == ST_RDATA) || (state_q == ST_RACK);
  assign read_mode_out = rd_q;

endmodule : isf_target

`default_nettype wire

// ===== tb/isf_target_props.sv
// Purpose: concurrent checks on the ports of the serial target front end
// Assumes: one system clock domain, synchronous reset high
// Notes: bound to every isf_target instance
`timescale 1ns/1ps
`default_nettype none

module isf_target_props import isf_pkg::*; (
  input wire logic clock_in,                 // system clock
  input wire logic reset_in,                 // reset, high
  input wire logic scl_in,                   // serial clock
  input wire logic sda_in,                   // data level
  input wire logic sda_out,                  // drive value
  input wire logic sda_oe_out,               // drive enable
  input wire logic [1:0] addr_strap_high_in, // upper strap
  input wire logic [1:0] addr_strap_low_in,  // lower strap
  input wire logic [6:0] own_addr_out,       // own address
  input wire logic start_out,                // start pulse
  input wire logic stop_out,                 // stop pulse
  input wire logic selected_out,             // addressed
  input wire logic read_mode_out,            // direction
  input wire logic rx_valid_out,             // byte waiting
  input wire logic [7:0] rx_data_out,        // byte
  input wire logic rx_cmd_out,               // command flag
  input wire logic rx_ready_in,              // byte taken
  input wire logic [7:0] tx_data_in,         // read byte
  input wire logic tx_load_out               // read byte taken
);
  // ----------------------------------------------------------------------
  // checks, all on the system clock
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  drive_low_a: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  addr_fixed_a: assert property (own_addr_out != 7'h00 |-> own_addr_out[6:4] == 3'h4)
    else $error("upper address bits wrong");
  addr_hold_a: assert property (own_addr_out != 7'h00 |=> $stable(own_addr_out))
    else $error("own address moved after capture");
  start_seen_a: assert property (start_out |-> !sda_in ##1 !start_out)
    else $error("start pulse without low data or too long");
  stop_seen_a: assert property (stop_out |-> sda_in && scl_in ##1 !stop_out)
    else $error("stop pulse without idle bus or too long");
  stop_free_a: assert property (stop_out |-> ##[0:3] !selected_out)
    else $error("still selected after stop");
  oe_clock_low_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed while clock high");
  drive_owner_a: assert property (sda_oe_out |-> selected_out)
    else $error("data pulled while not addressed");
  rx_hold_a: assert property (rx_valid_out && !rx_ready_in |=>
    rx_valid_out && $stable(rx_data_out) && $stable(rx_cmd_out))
    else $error("stalled byte lost or changed");
  tx_pulse_a: assert property (tx_load_out |-> read_mode_out && selected_out ##1 !tx_load_out)
    else $error("read byte load outside a read");
endmodule : isf_target_props

bind isf_target isf_target_props chk_u (
  .clock_in, .reset_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
  .addr_strap_high_in, .addr_strap_low_in, .own_addr_out, .start_out, .stop_out,
  .selected_out, .read_mode_out, .rx_valid_out, .rx_data_out, .rx_cmd_out,
  .rx_ready_in, .tx_data_in, .tx_load_out
);

`default_nettype wire

// ===== tb/isf_master_model.sv
// Purpose: behavioural serial bus master driving clock and data
// Assumes: bench resolves the open-drain data line with a pull-up
// Notes: clock stands high between frames; q sets speed (20 ns gives 80 ns bits)
`timescale 1ns/1ps
`default_nettype none

module isf_master_model (
  output logic scl_out,    // serial clock
  output logic sda_oe_out, // high while pulling data low
  input wire logic sda_in  // resolved data level
);
  int q = 20; // quarter bit; 80 ns bits keep the run short, above the bus limit

  // ----------------------------------------------------------------------
  // bus conditions and bits
  // ----------------------------------------------------------------------
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // start, also as repeated start from clock low
  task automatic start_c();
    sda_oe_out = 1'b0;
    #(q);
    scl_out = 1'b1;
    #(q);
    sda_oe_out = 1'b1;
    #(q);
    scl_out = 1'b0;
  endtask : start_c

  // stop in the clock after the last acknowledge
  task automatic stop_c();
    #(q);
    sda_oe_out = 1'b1;
    #(q);
    scl_out = 1'b1;
    #(q);
    sda_oe_out = 1'b0;
    #(q);
  endtask : stop_c

  // data moves only in the low half, sampled mid high
  task automatic bit_c(input logic b, output logic got);
    #(q);
    sda_oe_out = ~b;
    #(q);
    scl_out = 1'b1;
    #(q);
    got = sda_in;
    #(q);
    scl_out = 1'b0;
  endtask : bit_c

  // n bits msb first; a whole byte adds the acknowledge clock
  task automatic byte_c(input logic [7:0] b, input int n, input logic ack_drv,
                        output logic [7:0] got, output logic ack);
    for (int i = 7; i > 7 - n; i--) bit_c(b[i], got[i]);
    if (n == 8) bit_c(ack_drv, ack);
  endtask : byte_c
endmodule : isf_master_model

`default_nettype wire

// ===== tb/tb_isf_target.sv
// Purpose: self-checking bench of the serial target front end
// Assumes: master model on the far side, pull-up on the data line
// Notes: strap codes decoded outside, handed in as pad codes
`timescale 1ns/1ps
`default_nettype none

module tb_isf_target;
  import isf_pkg::*;
  localparam logic [6:0] ADDR = 7'h49; // straps high 2, low 1
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] strap_hi = 2'h2;
  logic [1:0] strap_lo = 2'h1;
  logic rx_ready = 1'b0;
  logic [7:0] tx_tab [2] = '{8'hC3, 8'h5A};
  logic tx_idx = 1'b0;
  logic [7:0] got;
  logic ack;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int n_start = 0;
  int n_stop = 0;
  wire scl, m_oe, d_oe, sda, d_out, sel, rmode, rxv, rxc, start_p, stop_p, txl;
  wire [7:0] rxd;
  wire [6:0] own;

  // ----------------------------------------------------------------------
  // clock, bus, instances
  // ----------------------------------------------------------------------
  initial forever #2.5 clock_in = ~clock_in;
  assign sda = ~(m_oe | d_oe); // pulled high unless someone pulls low

  isf_target dut_u (.clock_in(clock_in), .reset_in(reset_in), .scl_in(scl),
    .sda_in(sda), .sda_out(d_out), .sda_oe_out(d_oe), .addr_strap_high_in(strap_hi),
    .addr_strap_low_in(strap_lo), .own_addr_out(own), .start_out(start_p),
    .stop_out(stop_p), .selected_out(sel), .read_mode_out(rmode), .rx_valid_out(rxv),
    .rx_data_out(rxd), .rx_cmd_out(rxc), .rx_ready_in(rx_ready),
    .tx_data_in(tx_tab[tx_idx]), .tx_load_out(txl));
  isf_master_model m_u (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));

  // pulse counters, read byte feed and hang guard
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (start_p === 1'b1) n_start <= n_start + 1;
    if (stop_p === 1'b1) n_stop <= n_stop + 1;
    if (txl === 1'b1) tx_idx <= ~tx_idx;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // compare and helper tasks
  // ----------------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic g, input logic e, input string m);
    chk_byte({7'h00, g}, {7'h00, e}, m);
  endtask : chk_bit

  task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
    @(posedge clock_in);
    #1 reset_in = 1'b1;
    strap_hi = hi;
    strap_lo = lo;
    repeat (4) @(posedge clock_in);
    #1 reset_in = 1'b0;
    repeat (6) @(posedge clock_in);
    #1;
  endtask : do_reset

  task automatic frame_addr(input logic [6:0] a, input logic rw, input logic exp_ack);
    m_u.start_c();
    m_u.byte_c({a, rw}, 8, 1'b1, got, ack);
    chk_bit(ack, exp_ack, "address acknowledge");
  endtask : frame_addr

  task automatic pop(input logic [7:0] e, input logic cmd);
    chk_bit(rxv, 1'b1, "byte waiting");
    chk_byte(rxd, e, "received byte");
    chk_bit(rxc, cmd, "command flag");
    @(posedge clock_in);
    #1 rx_ready = 1'b1;
    @(posedge clock_in);
    #1 rx_ready = 1'b0;
  endtask : pop

  task automatic settle_idle();
    repeat (10) @(posedge clock_in);
    #1;
    chk_bit(sel, 1'b0, "released after stop");
  endtask : settle_idle

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_straps();
    for (int k = 0; k < 16; k++) begin
      do_reset(2'(k >> 2), 2'(k));
      chk_byte({1'b0, own}, {1'b0, 3'h4, 4'(k)}, "own address");
    end
    do_reset(2'h2, 2'h1);
  endtask : t_straps

  // stalled receiver: two bytes fit, the third is refused
  task automatic t_write();
    int s0;
    int p0;
    s0 = n_start;
    p0 = n_stop;
    frame_addr(ADDR, 1'b0, 1'b0);
    m_u.byte_c(8'hA5, 8, 1'b1, got, ack);
    chk_bit(ack, 1'b0, "command byte ack");
    m_u.byte_c(8'h3C, 8, 1'b1, got, ack);
    chk_bit(ack, 1'b0, "data byte ack");
    m_u.byte_c(8'h77, 8, 1'b1, got, ack);
    chk_bit(ack, 1'b1, "full buffer refuses");
    m_u.stop_c();
    settle_idle();
    chk_byte(8'(n_start - s0), 8'h01, "start count");
    chk_byte(8'(n_stop - p0), 8'h01, "stop count");
    pop(8'hA5, 1'b1);
    pop(8'h3C, 1'b0);
    chk_bit(rxv, 1'b0, "buffer drained");
  endtask : t_write

  task automatic t_mismatch();
    frame_addr(ADDR ^ 7'h01, 1'b0, 1'b1);
    m_u.byte_c(8'h00, 8, 1'b1, got, ack);
    chk_bit(ack, 1'b1, "idle after mismatch");
    m_u.stop_c();
    settle_idle();
    chk_bit(rxv, 1'b0, "nothing stored");
  endtask : t_mismatch

  task automatic t_quick();
    frame_addr(ADDR, 1'b0, 1'b0);
    m_u.stop_c();
    settle_idle();
    chk_bit(rxv, 1'b0, "presence check stores nothing");
  endtask : t_quick

  task automatic t_read();
    frame_addr(ADDR, 1'b1, 1'b0);
    chk_bit(rmode, 1'b1, "read direction");
    m_u.byte_c(8'hFF, 8, 1'b0, got, ack);
    chk_byte(got, 8'hC3, "first read byte");
    m_u.byte_c(8'hFF, 8, 1'b1, got, ack);
    chk_byte(got, 8'h5A, "second read byte");
    chk_bit(ack, 1'b1, "no acknowledge left high");
    m_u.stop_c();
    settle_idle();
  endtask : t_read

  // slow clock, partial address cut by a repeated start
  task automatic t_restart();
    m_u.q = 100;
    m_u.start_c();
    m_u.byte_c({ADDR, 1'b0}, 4, 1'b1, got, ack);
    frame_addr(ADDR, 1'b0, 1'b0);
    m_u.byte_c(8'h96, 8, 1'b1, got, ack);
    chk_bit(ack, 1'b0, "byte after restart ack");
    m_u.stop_c();
    m_u.q = 20;
    settle_idle();
    pop(8'h96, 1'b1);
    chk_bit(rxv, 1'b0, "only one byte kept");
  endtask : t_restart

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4) @(posedge clock_in);
    #1 reset_in = 1'b0;
    t_straps();
    t_write();
    t_mismatch();
    t_quick();
    t_read();
    t_restart();
    tally_and_finish();
  end
endmodule : tb_isf_target

`default_nettype wire
